// >>> pkfdp_map.svh
// Purpose: Register indices, field positions and reset values of the
//          packet FIFO data port.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef PKFDP_MAP_SVH
`define PKFDP_MAP_SVH

// ==========================================================
// Register indices
`define PKFDP_IDX_PACKET_CONTROL_REGISTER    8'h05
`define PKFDP_IDX_IRQ_STATUS  8'h0E
`define PKFDP_IDX_IRQ_MASK    8'h0F
`define PKFDP_IDX_STATE_CLEAR_REGISTER   8'h16
`define PKFDP_IDX_FIFO_SET    8'h78
`define PKFDP_IDX_TX_LEN_HI   8'h7A
`define PKFDP_IDX_TX_LEN_LO   8'h7B
`define PKFDP_IDX_TX_WR_PORT  8'h7C
`define PKFDP_IDX_RX_LEN_HI   8'h7D
`define PKFDP_IDX_RX_LEN_LO   8'h7E
`define PKFDP_IDX_RD_PORT     8'h7F

// ==========================================================
// Field positions
`define PKFDP_BIT_LEN_MODE    0
`define PKFDP_POS_FORMAT_LO   1
`define PKFDP_POS_FORMAT_HI   2
`define PKFDP_BIT_TX_PTR_CLR  0
`define PKFDP_BIT_RX_PTR_CLR  1
`define PKFDP_BIT_READ_SEL    0
`define PKFDP_BIT_IRQ_TX_ERR  0
`define PKFDP_BIT_IRQ_RX_OVW  1
`define PKFDP_BIT_IRQ_TX_DONE 2

// ==========================================================
// Reset values
`define PKFDP_RST_BYTE        8'h00
`define PKFDP_RST_FIFO_SET    8'h02
`define PKFDP_RST_LEN         16'h0000

// ==========================================================
// Storage
`define PKFDP_FIFO_AW         6

`endif

// >>> pkfdp_pkg.sv
// Purpose: Types shared by the packet FIFO data port.
// Assumes: APB with 32-bit data and a 10-bit byte address.
// Notes:   Constants live in pkfdp_map.svh.
package pkfdp_pkg;

	// ==========================================================
	// Packet formats, in the order of their 2-bit encoding
	typedef enum logic [1:0] {
		FMT_A,
		FMT_B,
		FMT_C,
		FMT_D
	} pkfdp_format_t;

	// ==========================================================
	// Bus carriers
	typedef struct packed {
		logic [9:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} pkfdp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pkfdp_apb_rsp_t;

	// ==========================================================
	// Packet engine carriers
	typedef struct packed {
		logic accept;
		logic complete;
		logic pop;
	} pkfdp_tx_evt_t;

	typedef struct packed {
		logic        start;
		logic        push;
		logic [7:0]  data;
		logic        len_load;
		logic [15:0] len;
	} pkfdp_rx_evt_t;

endpackage

// >>> pkfdp_byte_store.sv
// Purpose: Flip-flop byte store with write and read pointers.
// Assumes: A clear and a write in one cycle store at entry zero.
// Notes:   Pointers wrap, so old data is overwritten silently.
module pkfdp_byte_store #(
	parameter int AW = 6
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_clear,
	input  wire logic          i_wr,
	input  wire logic [7:0]    i_wdata,
	input  wire logic          i_rd,
	output logic      [7:0]    o_rdata,
	output logic      [AW-1:0] o_wr_ptr
);

	localparam int DEPTH = 1 << AW;

	logic [7:0]    mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW-1:0] wr_idx;

	// ==========================================================
	// Pointers
	assign wr_idx = i_clear ? '0 : wr_ptr_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_q <= '0;
		end else if (i_wr) begin
			wr_ptr_q <= wr_idx + AW'(1);
		end else if (i_clear) begin
			wr_ptr_q <= '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_ptr_q <= '0;
		end else if (i_clear) begin
			rd_ptr_q <= '0;
		end else if (i_rd) begin
			rd_ptr_q <= rd_ptr_q + AW'(1);
		end
	end

	// ==========================================================
	// Storage
	// Cleared at reset so the read port shows zero before any write
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mem_q <= '{default: 8'h00};
		end else if (i_wr) begin
			mem_q[wr_idx] <= i_wdata;
		end
	end

	assign o_rdata  = mem_q[rd_ptr_q];
	assign o_wr_ptr = wr_ptr_q;

endmodule // pkfdp_byte_store

// >>> pkfdp_top.sv
// Purpose: Packet FIFO access logic: TX length, TX write port, RX length,
//          shared FIFO read port, pointer clears and access errors.
// Assumes: Packet engine runs on i_clk; APB slave with one wait state.
// Notes:   Register byte address is four times its index.
//
// Register access over APB was decided locally.
`include "pkfdp_map.svh"

// Summary of operation
// - The TX length counts payload per format: A without length and CRC, B and C without length, D from data through CRC.
// - The TX length is high and low bytes, and the high byte only counts when the length-width bit is one.
// - The TX FIFO holds one packet of transmit data of up to 64 bytes; a longer packet wraps and overwrites its first bytes.
// - A TX write between request accepted and transmit complete overwrites the FIFO and raises the access error.
// - Writing one to state-clear bit 0 resets the TX FIFO pointer after an access error.
// - For formats A, B and C the read-only RX length shows the received length without the length field.
// - For format D the RX length register sets the receive length that controls the RX FIFO.
// - Each read of the shared read port returns a byte from the FIFO that the read-select bit names.
// - The RX FIFO keeps one packet, and a new packet overwrites the stored one.
// - Writing one to state-clear bit 1 resets the RX FIFO pointer after an abandoned read.
// - Read-select zero picks the RX FIFO and one picks the TX FIFO.
module pkfdp_top (
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	input  wire pkfdp_pkg::pkfdp_apb_req_t i_apb,
	output pkfdp_pkg::pkfdp_apb_rsp_t    o_apb,
	input  wire pkfdp_pkg::pkfdp_tx_evt_t  i_tx_evt,
	output logic [7:0]                   o_tx_data,
	output logic [15:0]                  o_tx_length_value,
	output logic                         o_tx_full,
	input  wire pkfdp_pkg::pkfdp_rx_evt_t  i_rx_evt,
	output logic [15:0]                  o_rx_length_value,
	output pkfdp_pkg::pkfdp_format_t     o_format,
	output logic                         o_irq
);

	localparam int AW = `PKFDP_FIFO_AW;

	// ==========================================================
	// Declarations
	logic                     ack_q;
	logic                     done;
	logic [7:0]               idx;
	logic                     hit;
	logic [7:0]               rd_val;
	logic [31:0]              prdata_q;
	logic                     wr_en;
	logic                     rd_en;

	logic [7:0]               packet_control_register_q;
	logic [7:0]               fifo_set_q;
	logic [7:0]               tx_len_hi_q;
	logic [7:0]               tx_len_lo_q;
	logic [15:0]              rx_len_q;
	logic [7:0]               irq_status_q;
	logic [7:0]               irq_mask_q;
	logic [7:0]               irq_set;

	logic                     length_mode;
	pkfdp_pkg::pkfdp_format_t fmt;
	logic                     read_sel;
	logic [15:0]              tx_len_eff;

	logic                     tx_wr;
	logic                     tx_host_rd;
	logic                     rx_host_rd;
	logic                     clr_wr;
	logic                     tx_ptr_clr;
	logic                     rx_ptr_clr;
	logic                     tx_locked_q;
	logic [15:0]              tx_cnt_q;
	logic                     tx_restart;
	logic                     tx_err;
	logic [7:0]               tx_rdata;

	logic [15:0]              rx_cnt_q;
	logic                     rx_room;
	logic                     rx_push;
	logic                     rx_clear;
	logic                     rx_ovw;
	logic [7:0]               rx_rdata;

	// ==========================================================
	// APB slave: one wait state, response on the second access cycle
	assign idx = i_apb.paddr[9:2];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= i_apb.psel & i_apb.penable & ~ack_q;
		end
	end

	assign done  = i_apb.psel & i_apb.penable & ack_q;
	assign wr_en = done & i_apb.pwrite & hit;
	assign rd_en = done & ~i_apb.pwrite & hit;

	// Read mux; an unaligned or unmapped address is not a hit
	always_comb begin
		hit    = 1'b1;
		rd_val = 8'h00;
		if (i_apb.paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (idx == `PKFDP_IDX_PACKET_CONTROL_REGISTER) begin
			rd_val = packet_control_register_q;
		end else if (idx == `PKFDP_IDX_IRQ_STATUS) begin
			rd_val = irq_status_q;
		end else if (idx == `PKFDP_IDX_IRQ_MASK) begin
			rd_val = irq_mask_q;
		end else if (idx == `PKFDP_IDX_STATE_CLEAR_REGISTER) begin
			rd_val = 8'h00;
		end else if (idx == `PKFDP_IDX_FIFO_SET) begin
			rd_val = fifo_set_q;
		end else if (idx == `PKFDP_IDX_TX_LEN_HI) begin
			rd_val = tx_len_hi_q;
		end else if (idx == `PKFDP_IDX_TX_LEN_LO) begin
			rd_val = tx_len_lo_q;
		end else if (idx == `PKFDP_IDX_TX_WR_PORT) begin
			rd_val = 8'h00;
		end else if (idx == `PKFDP_IDX_RX_LEN_HI) begin
			rd_val = rx_len_q[15:8];
		end else if (idx == `PKFDP_IDX_RX_LEN_LO) begin
			rd_val = rx_len_q[7:0];
		end else if (idx == `PKFDP_IDX_RD_PORT) begin
			rd_val = read_sel ? tx_rdata : rx_rdata;
		end else begin
			hit = 1'b0;
		end
	end

	// Read data is caught in the first access cycle, before any pop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (i_apb.psel & i_apb.penable & ~ack_q) begin
			prdata_q <= {24'h00_0000, rd_val};
		end
	end

	assign o_apb.prdata  = prdata_q;
	assign o_apb.pready  = done;
	assign o_apb.pslverr = done & ~hit;

	// ==========================================================
	// Control registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			packet_control_register_q <= `PKFDP_RST_BYTE;
		end else if (wr_en && idx == `PKFDP_IDX_PACKET_CONTROL_REGISTER) begin
			packet_control_register_q <= i_apb.pwdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fifo_set_q <= `PKFDP_RST_FIFO_SET;
		end else if (wr_en && idx == `PKFDP_IDX_FIFO_SET) begin
			fifo_set_q <= i_apb.pwdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_len_hi_q <= `PKFDP_RST_BYTE;
		end else if (wr_en && idx == `PKFDP_IDX_TX_LEN_HI) begin
			tx_len_hi_q <= i_apb.pwdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_len_lo_q <= `PKFDP_RST_BYTE;
		end else if (wr_en && idx == `PKFDP_IDX_TX_LEN_LO) begin
			tx_len_lo_q <= i_apb.pwdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_mask_q <= `PKFDP_RST_BYTE;
		end else if (wr_en && idx == `PKFDP_IDX_IRQ_MASK) begin
			irq_mask_q <= i_apb.pwdata[7:0];
		end
	end

	assign length_mode = packet_control_register_q[`PKFDP_BIT_LEN_MODE];
	assign fmt         = pkfdp_pkg::pkfdp_format_t'(
		packet_control_register_q[`PKFDP_POS_FORMAT_HI:`PKFDP_POS_FORMAT_LO]);
	assign read_sel    = fifo_set_q[`PKFDP_BIT_READ_SEL];

	// Length counting per format is the engine's job; the value is passed
	assign tx_len_eff = length_mode ? {tx_len_hi_q, tx_len_lo_q}
		: {8'h00, tx_len_lo_q};

	// ==========================================================
	// Port strobes
	assign tx_wr      = wr_en && idx == `PKFDP_IDX_TX_WR_PORT;
	assign tx_host_rd = rd_en && idx == `PKFDP_IDX_RD_PORT && read_sel;
	assign rx_host_rd = rd_en && idx == `PKFDP_IDX_RD_PORT && !read_sel;
	assign clr_wr     = wr_en && idx == `PKFDP_IDX_STATE_CLEAR_REGISTER;
	assign tx_ptr_clr = clr_wr & i_apb.pwdata[`PKFDP_BIT_TX_PTR_CLR];
	assign rx_ptr_clr = clr_wr & i_apb.pwdata[`PKFDP_BIT_RX_PTR_CLR];

	// ==========================================================
	// TX FIFO
	// Locked from request accepted until transmit complete or a TX pointer clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_locked_q <= 1'b0;
		end else if (i_tx_evt.complete | tx_ptr_clr) begin
			tx_locked_q <= 1'b0;
		end else if (i_tx_evt.accept) begin
			tx_locked_q <= 1'b1;
		end
	end

	// A write into a locked or already full packet starts it over
	assign tx_restart = tx_wr & (tx_locked_q | (tx_cnt_q >= tx_len_eff));
	assign tx_err     = tx_wr & tx_locked_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_cnt_q <= `PKFDP_RST_LEN;
		end else if (tx_ptr_clr) begin
			tx_cnt_q <= `PKFDP_RST_LEN;
		end else if (tx_restart) begin
			tx_cnt_q <= 16'h0001;
		end else if (tx_wr) begin
			tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	// Host and engine reads in one cycle advance the pointer only once
	pkfdp_byte_store #(
		.AW (AW)
	) u_tx_store (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_clear  (tx_ptr_clr | tx_restart),
		.i_wr     (tx_wr),
		.i_wdata  (i_apb.pwdata[7:0]),
		.i_rd     (tx_host_rd | i_tx_evt.pop),
		.o_rdata  (tx_rdata),
		.o_wr_ptr ()
	);

	assign o_tx_data         = tx_rdata;
	assign o_tx_length_value = tx_len_eff;
	assign o_tx_full         = tx_cnt_q >= tx_len_eff;

	// ==========================================================
	// RX length: engine reports it for A to C, host sets it for D
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_len_q <= `PKFDP_RST_LEN;
		end else if (fmt == pkfdp_pkg::FMT_D) begin
			if (wr_en && idx == `PKFDP_IDX_RX_LEN_HI) begin
				rx_len_q[15:8] <= i_apb.pwdata[7:0];
			end else if (wr_en && idx == `PKFDP_IDX_RX_LEN_LO) begin
				rx_len_q[7:0] <= i_apb.pwdata[7:0];
			end
		end else if (i_rx_evt.len_load) begin
			rx_len_q <= i_rx_evt.len;
		end
	end

	assign o_rx_length_value = rx_len_q;

	// ==========================================================
	// RX FIFO
	// Format D bounds the stored bytes by the RX length register, though the byte pushed with start always lands
	assign rx_room  = (fmt != pkfdp_pkg::FMT_D) || (rx_cnt_q < rx_len_q);
	assign rx_clear = rx_ptr_clr | i_rx_evt.start;
	assign rx_push  = i_rx_evt.push & (rx_room | i_rx_evt.start);
	assign rx_ovw   = i_rx_evt.start & (rx_cnt_q != 16'h0000);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_cnt_q <= `PKFDP_RST_LEN;
		end else if (rx_clear) begin
			rx_cnt_q <= rx_push ? 16'h0001 : 16'h0000;
		end else if (rx_push) begin
			rx_cnt_q <= rx_cnt_q + 16'h0001;
		end
	end

	pkfdp_byte_store #(
		.AW (AW)
	) u_rx_store (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_clear  (rx_clear),
		.i_wr     (rx_push),
		.i_wdata  (i_rx_evt.data),
		.i_rd     (rx_host_rd),
		.o_rdata  (rx_rdata),
		.o_wr_ptr ()
	);

	assign o_format = fmt;

	// ==========================================================
	// Interrupts: set wins over the clearing read
	always_comb begin
		irq_set                         = 8'h00;
		irq_set[`PKFDP_BIT_IRQ_TX_ERR]  = tx_err;
		irq_set[`PKFDP_BIT_IRQ_RX_OVW]  = rx_ovw;
		irq_set[`PKFDP_BIT_IRQ_TX_DONE] = i_tx_evt.complete;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_status_q <= `PKFDP_RST_BYTE;
		end else if (rd_en && idx == `PKFDP_IDX_IRQ_STATUS) begin
			// Clear only what the read reported, so a later set is kept
			irq_status_q <= (irq_status_q & ~prdata_q[7:0]) | irq_set;
		end else begin
			irq_status_q <= irq_status_q | irq_set;
		end
	end

	assign o_irq = |(irq_status_q & irq_mask_q);

endmodule // pkfdp_top

// >>> pkfdp_checker.sv
// Purpose: Port checker for the packet FIFO data port.
// Assumes: Register byte address is four times its index.
// Notes:   Mirrors only what the bus shows; lock and fill state are guesses.
module pkfdp_chk (
	input wire logic                      i_clk,
	input wire logic                      i_rst,
	input wire pkfdp_pkg::pkfdp_apb_req_t i_apb,
	input wire pkfdp_pkg::pkfdp_apb_rsp_t o_apb,
	input wire pkfdp_pkg::pkfdp_tx_evt_t  i_tx_evt,
	input wire logic [7:0]                o_tx_data,
	input wire logic [15:0]               o_tx_length_value,
	input wire logic                      o_tx_full,
	input wire pkfdp_pkg::pkfdp_rx_evt_t  i_rx_evt,
	input wire logic [15:0]               o_rx_length_value,
	input wire pkfdp_pkg::pkfdp_format_t  o_format,
	input wire logic                      o_irq
);
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic [1:0] clr;
	logic       mode_q, lock_q, rxany_q;
	logic [7:0] hi_q, lo_q, mask_q;
	assign wr  = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite;
	assign rd  = i_apb.psel & i_apb.penable & o_apb.pready & !i_apb.pwrite;
	assign idx = i_apb.paddr[9:2];
	assign clr = (wr && idx == 8'h16) ? i_apb.pwdata[1:0] : 2'h0;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// Bus mirror
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			{mode_q, hi_q, lo_q, mask_q} <= '0;
		end else if (wr && i_apb.paddr[1:0] == 2'h0) begin
			if (idx == 8'h05) mode_q <= i_apb.pwdata[0];
			if (idx == 8'h7A) hi_q <= i_apb.pwdata[7:0];
			if (idx == 8'h7B) lo_q <= i_apb.pwdata[7:0];
			if (idx == 8'h0F) mask_q <= i_apb.pwdata[7:0];
		end
	end
	// Stored-bytes flag: the RX pointer clear empties the packet too
	always_ff @(posedge i_clk) begin
		if (i_rst) rxany_q <= 1'b0;
		else if (i_rx_evt.start) rxany_q <= i_rx_evt.push;
		else if (clr[1]) rxany_q <= i_rx_evt.push;
		else if (i_rx_evt.push) rxany_q <= 1'b1;
	end
	// Unlock wins over a same-cycle accept
	always_ff @(posedge i_clk) begin
		if (i_rst) lock_q <= 1'b0;
		else if (i_tx_evt.complete | clr[0]) lock_q <= 1'b0;
		else if (i_tx_evt.accept) lock_q <= 1'b1;
	end
	// ==========================================================
	// Properties
	property p_txlen;
		o_tx_length_value == {mode_q ? hi_q : 8'h00, lo_q};
	endproperty
	property p_rxld;
		i_rx_evt.len_load && o_format != pkfdp_pkg::FMT_D
			|=> o_rx_length_value == $past(i_rx_evt.len);
	endproperty
	property p_rxro;
		wr && idx == 8'h7E && o_format != pkfdp_pkg::FMT_D
			&& !i_rx_evt.len_load && !i_rx_evt.start
			|=> $stable(o_rx_length_value);
	endproperty
	property p_fmtd;
		wr && idx == 8'h7E && o_format == pkfdp_pkg::FMT_D
			|=> o_rx_length_value[7:0] == $past(i_apb.pwdata[7:0]);
	endproperty
	property p_txclr;
		clr[0] && o_tx_length_value != 16'h0000 |=> !o_tx_full;
	endproperty
	property p_lockerr;
		wr && idx == 8'h7C && lock_q && mask_q[0] |=> o_irq;
	endproperty
	property p_ovw;
		i_rx_evt.start && rxany_q && mask_q[1] |=> o_irq;
	endproperty
	property p_wait;
		i_apb.psel && !i_apb.penable |=> !o_apb.pready ##1 o_apb.pready;
	endproperty
	a_txlen: assert property (p_txlen) else $error("tx length");
	a_rxld: assert property (p_rxld) else $error("rx length load");
	a_rxro: assert property (p_rxro) else $error("rx length written");
	a_fmtd: assert property (p_fmtd) else $error("rx length fmt D");
	a_txclr: assert property (p_txclr) else $error("tx clear");
	a_lockerr: assert property (p_lockerr) else $error("no tx err");
	a_ovw: assert property (p_ovw) else $error("no rx overwrite");
	a_wait: assert property (p_wait) else $error("wait state");
	c_lock: cover property (wr && idx == 8'h7C && lock_q);
	c_ovw: cover property (i_rx_evt.start && rxany_q);
	c_rdp: cover property (rd && idx == 8'h7F);
endmodule // pkfdp_chk

bind pkfdp_top pkfdp_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_apb(i_apb), .o_apb(o_apb), .i_tx_evt(i_tx_evt),
	.o_tx_data(o_tx_data), .o_tx_length_value(o_tx_length_value),
	.o_tx_full(o_tx_full), .i_rx_evt(i_rx_evt),
	.o_rx_length_value(o_rx_length_value), .o_format(o_format),
	.o_irq(o_irq));

// >>> pkfdp_host.sv
// Purpose: Host model: APB master reaching the registers.
// Assumes: Byte address is four times the register index.
// Notes:   Waits on pready without limit; the bench timeout ends a hang.
module pkfdp_host (
	input  wire logic                      i_clk,
	input  wire pkfdp_pkg::pkfdp_apb_rsp_t i_rsp,
	output pkfdp_pkg::pkfdp_apb_req_t      o_req
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_req = '0;
	// ==========================================================
	// One transfer, request held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		@(posedge i_clk);
		o_req <= '{{idx, 2'b00}, 1'b1, 1'b0, w, {24'h0, d}};
		@(posedge i_clk);
		o_req.penable <= 1'b1;
		do @(posedge i_clk); while (i_rsp.pready !== 1'b1);
		o_req.psel <= 1'b0;
		o_req.penable <= 1'b0;
	endtask
endmodule // pkfdp_host

// >>> tb_packet_fifo_data_port.sv
// Purpose: Self-checking bench for the packet FIFO data port.
// Assumes: Host model drives APB; bench drives the packet engine side.
// Notes:   Read results are queued by the driver, judged by the monitor.
module tb_packet_fifo_data_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic                      i_clk = 1'b0;
	logic                      i_rst = 1'b1;
	pkfdp_pkg::pkfdp_apb_req_t apb_req;
	pkfdp_pkg::pkfdp_apb_rsp_t apb_rsp;
	pkfdp_pkg::pkfdp_tx_evt_t  tx_evt = '0;
	pkfdp_pkg::pkfdp_rx_evt_t  rx_evt = '0;
	pkfdp_pkg::pkfdp_format_t  fmt;
	logic [7:0]                tx_data;
	logic [15:0]               tx_len, rx_len;
	logic                      tx_full, irq;
	logic [32:0]               exp_q[$];
	logic [7:0]                b[4];
	logic [7:0]                ridx[7] = '{8'h7A, 8'h7B, 8'h7D, 8'h7E,
		8'h7F, 8'h78, 8'h16};
	logic [7:0]                rval[7] = '{0, 0, 0, 0, 0, 8'h02, 0};
	int                        bad_count = 0;
	int                        n_checks = 0;
	int                        cyc = 0;
	pkfdp_host host (.i_clk(i_clk), .i_rsp(apb_rsp), .o_req(apb_req));
	pkfdp_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb_req),
		.o_apb(apb_rsp), .i_tx_evt(tx_evt), .o_tx_data(tx_data),
		.o_tx_length_value(tx_len), .o_tx_full(tx_full),
		.i_rx_evt(rx_evt), .o_rx_length_value(rx_len),
		.o_format(fmt), .o_irq(irq));
	// ==========================================================
	// Tasks
	task automatic check(input logic [32:0] got, input logic [32:0] e);
		n_checks++;
		if (got !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		host.xfer(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [8:0] e);
		exp_q.push_back({e[8], 24'h0, e[7:0]});
		host.xfer(1'b0, idx, 8'h00);
	endtask
	task automatic tx(input logic [2:0] e);
		@(posedge i_clk);
		tx_evt <= e;
		@(posedge i_clk);
		tx_evt <= '0;
	endtask
	task automatic rx(input logic [26:0] e);
		@(posedge i_clk);
		rx_evt <= e;
		@(posedge i_clk);
		rx_evt <= '0;
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Clock, monitor and timeout
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1
			&& !apb_req.pwrite)
			check({apb_rsp.pslverr, apb_rsp.prdata},
				exp_q.size() ? exp_q.pop_front() : 33'bx);
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(15));
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (ridx[i]) rd(ridx[i], {1'b0, rval[i]});
		rd(8'h40, 9'h100);
		wr(8'h7A, 8'h12);
		wr(8'h7B, 8'h34);
		@(negedge i_clk);
		check(tx_len, 33'h34);
		wr(8'h05, 8'h01);
		@(negedge i_clk);
		check(tx_len, 33'h1234);
		rd(8'h7A, 9'h012);
		wr(8'h05, 8'h00);
		wr(8'h7B, 8'h04);
		wr(8'h0F, 8'h07);
		foreach (b[i]) begin
			b[i] = 8'($urandom);
			wr(8'h7C, b[i]);
		end
		@(negedge i_clk);
		check(tx_full, 33'h1);
		check(tx_data, b[0]);
		tx(3'b001);
		@(negedge i_clk);
		check(tx_data, b[1]);
		wr(8'h78, 8'h03);
		for (int i = 1; i < 4; i++) rd(8'h7F, {1'b0, b[i]});
		// Writing past a full packet restarts the store, not an error
		wr(8'h7C, 8'h5A);
		@(negedge i_clk);
		check({irq, tx_full}, 33'h0);
		tx(3'b100);
		wr(8'h7C, 8'hA5);
		@(negedge i_clk);
		check(irq, 33'h1);
		rd(8'h0E, 9'h001);
		@(negedge i_clk);
		check(irq, 33'h0);
		wr(8'h16, 8'h01);
		@(negedge i_clk);
		check(tx_full, 33'h0);
		wr(8'h7C, 8'h3C);
		tx(3'b010);
		rd(8'h0E, 9'h004);
		wr(8'h78, 8'h02);
		foreach (b[i]) b[i] = 8'($urandom);
		rx({2'b11, b[0], 1'b1, 16'h0003});
		rx({2'b01, b[1], 17'h0});
		@(negedge i_clk);
		check(rx_len, 33'h3);
		wr(8'h7E, 8'h55);
		rd(8'h7E, 9'h003);
		rd(8'h7F, {1'b0, b[0]});
		rx({2'b11, b[2], 17'h0});
		rd(8'h0E, 9'h002);
		rd(8'h7F, {1'b0, b[2]});
		wr(8'h16, 8'h02);
		rd(8'h7F, {1'b0, b[2]});
		wr(8'h05, 8'h06);
		wr(8'h7E, 8'h02);
		@(negedge i_clk);
		check({fmt, rx_len}, {2'h3, 16'h0002});
		rx({2'b11, b[3], 17'h0});
		rx({2'b01, b[1], 17'h0});
		// A third push is beyond the length and must not land
		rx({2'b01, 8'hC3, 17'h0});
		rd(8'h7F, {1'b0, b[3]});
		rd(8'h7F, {1'b0, b[1]});
		rd(8'h7F, 9'h000);
		// Masked event: status still records it, the line stays low
		wr(8'h0F, 8'h00);
		tx(3'b010);
		@(negedge i_clk);
		check(irq, 33'h0);
		rd(8'h0E, 9'h004);
		repeat (2) @(posedge i_clk);
		print_verdict();
	end
endmodule // tb_packet_fifo_data_port
